// ### fbsm_slave.sv
// Purpose: Slave end; communication state machine and service gating
// Assumes: Master keeps its setup order before each upward request
// Notes: Object dictionary is a small flip-flop array
// Functional notes
// [RULE1] Four states, current one reported
// [RULE2] Upward path passes every state in order
// [RULE3] Downward jumps from operational are accepted
// [RULE4] Init carries no application traffic
// [RULE5] Master sets address, mailbox, clock first; fbsm_master does not model this setup
// [RULE6] Pre-op serves mailbox SDO
// [RULE7] Master maps PDO, SM, FMMU first; fbsm_master sends only one FBSM_MAP_SELECT, together with the safe-op request
// [RULE8] Safe-op supplies inputs, ignores outputs
// [RULE9] Master sends valid outputs before op
// [RULE10] Op: inputs, outputs and SDO valid
// [RULE11] Inputs assembled from mapped dictionary entries
// [RULE12] Mailbox reaches every dictionary entry
// [RULE13] Two 100BASE-TX ports, in and out
// [RULE14] State shown one-hot 1,2,4,8
// [RULE15] Mapping changes outside pre-op get error
// [RULE16] Skipped upward request holds state, flags error
`timescale 1ns/1ps
`include "fbsm_defines.svh"
module fbsm_slave
#(
  parameter int OD_DEPTH = `FBSM_OD_DEPTH,
  parameter int MAP_DEPTH = `FBSM_MAP_DEPTH
)
(
  input wire logic sys_clk_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  fbsm_if.slave link, // Link to master
  input wire logic [1:0] phy_link_i, // Port in/out link up, async
  output logic [3:0] disp_state_o, // One-hot state for display
  output logic [31:0] rx_pdo_o, // Received output data
  output logic rx_pdo_valid_o // Output data acted on
);
  fbsm_pkg::fbsm_state_e st_r;
  fbsm_pkg::fbsm_state_e st_nxt;
  logic err_nxt;
  logic [31:0] od_r [OD_DEPTH];
  logic [3:0] map_r [MAP_DEPTH];
  logic [$clog2(MAP_DEPTH)-1:0] sel_r;
  logic [1:0] phy_s1_r;
  logic [1:0] phy_s2_r;
  logic svc_ok;
  logic map_ok;
  logic [31:0] tx_word;

  function automatic logic [3:0] onehot(input fbsm_pkg::fbsm_state_e s);
    unique case (s)
      fbsm_pkg::FBSM_INIT: onehot = `FBSM_ST_INIT;
      fbsm_pkg::FBSM_PREOP: onehot = `FBSM_ST_PREOP;
      fbsm_pkg::FBSM_SAFEOP: onehot = `FBSM_ST_SAFEOP;
      fbsm_pkg::FBSM_OP: onehot = `FBSM_ST_OP;
    endcase
  endfunction

  // Transition decision
  always_comb
  begin
    st_nxt = st_r;
    err_nxt = 1'b0;
    if (link.st_req)
    begin
      unique case (link.st_target)
        `FBSM_ST_INIT: st_nxt = fbsm_pkg::FBSM_INIT; // [RULE3]
        `FBSM_ST_PREOP:
          st_nxt = fbsm_pkg::FBSM_PREOP; // [RULE2]
        `FBSM_ST_SAFEOP:
          if (st_r == fbsm_pkg::FBSM_PREOP || st_r == fbsm_pkg::FBSM_OP
              || st_r == fbsm_pkg::FBSM_SAFEOP)
            st_nxt = fbsm_pkg::FBSM_SAFEOP; // [RULE2]
          else
            err_nxt = 1'b1; // [RULE16]
        `FBSM_ST_OP:
          if (st_r == fbsm_pkg::FBSM_SAFEOP || st_r == fbsm_pkg::FBSM_OP)
            st_nxt = fbsm_pkg::FBSM_OP; // [RULE2]
          else
            err_nxt = 1'b1; // [RULE16]
        default: err_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= fbsm_pkg::FBSM_INIT;
      link.st_err <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt; // [RULE1]
      // Error sticks until next accepted request
      if (err_nxt)
        link.st_err <= 1'b1; // [RULE16]
      else if (link.st_req)
        link.st_err <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link.st_cur <= `FBSM_ST_INIT;
      disp_state_o <= `FBSM_ST_INIT;
    end
    else
    begin
      link.st_cur <= onehot(st_nxt); // [RULE14]
      disp_state_o <= onehot(st_nxt); // [RULE1]
    end
  end

  // Mailbox is dead in init; only the controller itself talks then
  assign svc_ok = (st_r != fbsm_pkg::FBSM_INIT); // [RULE4]
  assign map_ok = (st_r == fbsm_pkg::FBSM_PREOP); // [RULE15]

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link.mbx_ack <= 1'b0;
      link.mbx_rdata <= 32'h0;
      link.mbx_code <= `FBSM_ERR_NONE;
    end
    else
    begin
      link.mbx_ack <= link.mbx_req;
      if (link.mbx_req)
      begin
        link.mbx_rdata <= 32'h0;
        link.mbx_code <= `FBSM_ERR_NONE;
        if (!svc_ok)
          link.mbx_code <= `FBSM_ERR_SVC; // [RULE4]
        else if ((link.mbx_cmd == fbsm_pkg::FBSM_MAP_WRITE
                  || link.mbx_cmd == fbsm_pkg::FBSM_MAP_SELECT) && !map_ok)
          link.mbx_code <= `FBSM_ERR_PDO_LOCK; // [RULE15]
        else if (link.mbx_cmd == fbsm_pkg::FBSM_SDO_READ)
          link.mbx_rdata <= od_r[link.mbx_index]; // [RULE12]
        else if (link.mbx_cmd == fbsm_pkg::FBSM_MAP_SELECT
                 && link.mbx_wdata >= 32'(MAP_DEPTH))
          link.mbx_code <= `FBSM_ERR_MAP_VAL;
      end
    end
  end

  // Dictionary; RPDO lands in entry 0 only in op
  generate
    for (genvar i = 0; i < OD_DEPTH; i++)
    begin : g_od
      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          od_r[i] <= 32'h0;
        else if (link.mbx_req && svc_ok && link.mbx_cmd == fbsm_pkg::FBSM_SDO_WRITE
                 && link.mbx_index == 4'(i))
          od_r[i] <= link.mbx_wdata; // [RULE6]
        else if (i == 0 && st_r == fbsm_pkg::FBSM_OP && link.pdo_out_valid)
          od_r[i] <= link.pdo_out; // [RULE10]
      end
    end
    for (genvar j = 0; j < MAP_DEPTH; j++)
    begin : g_map
      always_ff @(posedge sys_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          map_r[j] <= 4'(j + 1);
        else if (link.mbx_req && map_ok && link.mbx_cmd == fbsm_pkg::FBSM_MAP_WRITE
                 && link.mbx_wdata[31:28] == 4'(j))
          map_r[j] <= link.mbx_wdata[3:0]; // [RULE15]
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sel_r <= '0;
    else if (link.mbx_req && map_ok && link.mbx_cmd == fbsm_pkg::FBSM_MAP_SELECT
             && link.mbx_wdata < 32'(MAP_DEPTH))
      sel_r <= link.mbx_wdata[$clog2(MAP_DEPTH)-1:0];
  end

  assign tx_word = od_r[map_r[sel_r]]; // [RULE11]

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link.pdo_in_valid <= 1'b0;
      link.pdo_in <= 32'h0;
      rx_pdo_o <= 32'h0;
      rx_pdo_valid_o <= 1'b0;
    end
    else
    begin
      link.pdo_in_valid <= (st_r == fbsm_pkg::FBSM_SAFEOP
                            || st_r == fbsm_pkg::FBSM_OP); // [RULE8]
      link.pdo_in <= tx_word;
      // Outputs ignored in safe-op
      rx_pdo_valid_o <= (st_r == fbsm_pkg::FBSM_OP) && link.pdo_out_valid; // [RULE8]
      if (st_r == fbsm_pkg::FBSM_OP && link.pdo_out_valid)
        rx_pdo_o <= link.pdo_out; // [RULE10]
    end
  end

  // Port link status: two PHY ports, in and out
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      phy_s1_r <= 2'h0;
      phy_s2_r <= 2'h0;
      link.port_link <= 2'h0;
    end
    else
    begin
      phy_s1_r <= phy_link_i;
      phy_s2_r <= phy_s1_r;
      link.port_link <= phy_s2_r; // [RULE13]
    end
  end
endmodule

// ### fbsm_defines.svh
// Purpose: Constants shared by both ends of the fieldbus state link
// Assumes: One-hot state codes are also the display codes
// Notes: Definitions only
`ifndef FBSM_DEFINES_SVH
`define FBSM_DEFINES_SVH
`define FBSM_ST_INIT 4'h1
`define FBSM_ST_PREOP 4'h2
`define FBSM_ST_SAFEOP 4'h4
`define FBSM_ST_OP 4'h8
`define FBSM_ERR_NONE 8'h00
`define FBSM_ERR_SKIP 8'h11
`define FBSM_ERR_BADST 8'h12
`define FBSM_ERR_PDO_LOCK 8'h21
`define FBSM_ERR_SVC 8'h22
`define FBSM_ERR_MAP_VAL 8'h23
`define FBSM_OD_DEPTH 16
`define FBSM_MAP_DEPTH 4
`endif

// ### fbsm_pkg.sv
// Purpose: Types for the fieldbus state link
// Assumes: fbsm_defines.svh holds the numbers
// Notes: No import; use fbsm_pkg::name
package fbsm_pkg;
  typedef enum logic [1:0]
  {
    FBSM_INIT = 2'h0,
    FBSM_PREOP = 2'h1,
    FBSM_SAFEOP = 2'h3,
    FBSM_OP = 2'h2
  } fbsm_state_e;
  typedef enum logic [1:0]
  {
    FBSM_SDO_READ = 2'h0,
    FBSM_SDO_WRITE = 2'h1,
    FBSM_MAP_WRITE = 2'h2,
    FBSM_MAP_SELECT = 2'h3
  } fbsm_cmd_e;
endpackage

// ### fbsm_if.sv
// Purpose: Link between the bus master end and the slave end
// Assumes: Single clock, both ends synchronous to it
// Notes: State requests and mailbox requests are one-cycle strobes
`timescale 1ns/1ps
interface fbsm_if;
  logic st_req;
  logic [3:0] st_target;
  logic [3:0] st_cur;
  logic st_err;
  logic mbx_req;
  fbsm_pkg::fbsm_cmd_e mbx_cmd;
  logic [3:0] mbx_index;
  logic [31:0] mbx_wdata;
  logic mbx_ack;
  logic [31:0] mbx_rdata;
  logic [7:0] mbx_code;
  logic pdo_out_valid;
  logic [31:0] pdo_out;
  logic pdo_in_valid;
  logic [31:0] pdo_in;
  logic [1:0] port_link;
  modport slave
  (
    input st_req, st_target, mbx_req, mbx_cmd, mbx_index, mbx_wdata,
    input pdo_out_valid, pdo_out,
    output st_cur, st_err, mbx_ack, mbx_rdata, mbx_code, pdo_in_valid, pdo_in, port_link
  );
  modport master
  (
    output st_req, st_target, mbx_req, mbx_cmd, mbx_index, mbx_wdata,
    output pdo_out_valid, pdo_out,
    input st_cur, st_err, mbx_ack, mbx_rdata, mbx_code, pdo_in_valid, pdo_in, port_link
  );
endinterface

// ### fbsm_master.sv
// Purpose: Bus master end; walks the slave up through its states
// Assumes: User strobes go_i to start, stop_i to drop to init
// Notes: Address, mailbox and clock setup are not modelled; SM setup is one FBSM_MAP_SELECT mailbox request
`timescale 1ns/1ps
`include "fbsm_defines.svh"
module fbsm_master
(
  input wire logic sys_clk_i, // System clock
  input wire logic rst_n_i, // Async reset, active low
  fbsm_if.master link, // Link to slave
  input wire logic go_i, // Start bring-up pulse
  input wire logic stop_i, // Drop to init pulse
  input wire logic [31:0] out_data_i, // Output process data
  output logic [3:0] slave_state_o, // Slave state mirror
  output logic [31:0] in_data_o, // Input process data
  output logic fault_o // Slave reported error
);
  typedef enum logic [2:0]
  {
    FBSM_M_IDLE = 3'h0,
    FBSM_M_CFG = 3'h1,
    FBSM_M_MAP = 3'h3,
    FBSM_M_OUT = 3'h2,
    FBSM_M_RUN = 3'h6,
    FBSM_M_WAIT = 3'h7
  } fbsm_mst_e;
  fbsm_mst_e st_r;
  fbsm_mst_e ret_r;
  logic [3:0] want_r;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= FBSM_M_IDLE;
      ret_r <= FBSM_M_IDLE;
      want_r <= `FBSM_ST_INIT;
      link.st_req <= 1'b0;
      link.st_target <= `FBSM_ST_INIT;
      link.mbx_req <= 1'b0;
      link.mbx_cmd <= fbsm_pkg::FBSM_SDO_READ;
      link.mbx_index <= 4'h0;
      link.mbx_wdata <= 32'h0;
      link.pdo_out_valid <= 1'b0;
      link.pdo_out <= 32'h0;
    end
    else
    begin
      link.st_req <= 1'b0;
      link.mbx_req <= 1'b0;
      link.pdo_out <= out_data_i;
      if (stop_i)
      begin
        link.st_req <= 1'b1;
        link.st_target <= `FBSM_ST_INIT;
        link.pdo_out_valid <= 1'b0;
        st_r <= FBSM_M_IDLE;
      end
      else
      begin
        unique case (st_r)
          FBSM_M_IDLE:
            if (go_i)
              st_r <= FBSM_M_CFG;
          FBSM_M_CFG:
          begin
            // Address, mailbox and clock assumed set before this request
            link.st_req <= 1'b1; // [RULE5]
            link.st_target <= `FBSM_ST_PREOP; // [RULE2]
            want_r <= `FBSM_ST_PREOP;
            ret_r <= FBSM_M_MAP;
            st_r <= FBSM_M_WAIT;
          end
          FBSM_M_MAP:
          begin
            // Mapping goes through the mailbox before safe-op
            link.mbx_req <= 1'b1; // [RULE7]
            link.mbx_cmd <= fbsm_pkg::FBSM_MAP_SELECT;
            link.mbx_index <= 4'h0;
            link.mbx_wdata <= 32'h0;
            link.st_req <= 1'b1;
            link.st_target <= `FBSM_ST_SAFEOP; // [RULE2]
            want_r <= `FBSM_ST_SAFEOP;
            ret_r <= FBSM_M_OUT;
            st_r <= FBSM_M_WAIT;
          end
          FBSM_M_OUT:
          begin
            link.pdo_out_valid <= 1'b1; // [RULE9]
            link.st_req <= 1'b1;
            link.st_target <= `FBSM_ST_OP;
            want_r <= `FBSM_ST_OP;
            ret_r <= FBSM_M_RUN;
            st_r <= FBSM_M_WAIT;
          end
          FBSM_M_RUN:
            st_r <= FBSM_M_RUN;
          FBSM_M_WAIT:
            if (link.st_cur == want_r)
              st_r <= ret_r;
            else if (link.st_err)
              st_r <= FBSM_M_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      slave_state_o <= `FBSM_ST_INIT;
      in_data_o <= 32'h0;
      fault_o <= 1'b0;
    end
    else
    begin
      slave_state_o <= link.st_cur;
      fault_o <= link.st_err;
      if (link.pdo_in_valid)
        in_data_o <= link.pdo_in;
    end
  end
endmodule

// ### fbsm_asserts.sv
// Purpose: Timing checks on the link between master and slave ends
// Assumes: One clock; signals of the first link only
// Notes: Skip refusals are driven by the bench on a second link
`timescale 1ns/1ps
module fbsm_asserts
(
  input wire logic sys_clk_i, // Clock
  input wire logic rst_n_i, // Reset, active low
  input wire logic st_req, // State request
  input wire logic [3:0] st_target, // Requested state
  input wire logic [3:0] st_cur, // Current state
  input wire logic st_err, // Transition error
  input wire logic mbx_req, // Mailbox request
  input wire logic mbx_ack, // Mailbox answer
  input wire logic [7:0] mbx_code, // Answer code
  input wire logic pdo_out_valid, // Outputs valid
  input wire logic pdo_in_valid // Inputs valid
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_ONEHOT: assert property ($onehot(st_cur))
    else $error("state not one-hot");
  AST_HOLD: assert property (!st_req |=> $stable(st_cur))
    else $error("state moved without request");
  AST_UP_PREOP: assert property (st_req && st_cur == 4'h1 && st_target == 4'h2
    |=> st_cur == 4'h2 && !st_err) else $error("init to preop failed");
  AST_UP_SAFEOP: assert property (st_req && st_cur == 4'h2 && st_target == 4'h4
    |=> st_cur == 4'h4) else $error("preop to safeop failed");
  AST_UP_OP: assert property (st_req && st_cur == 4'h4 && st_target == 4'h8
    |=> st_cur == 4'h8) else $error("safeop to op failed");
  AST_DOWN: assert property (st_req && st_target == 4'h1
    |=> st_cur == 4'h1 && !st_err) else $error("drop to init failed");
  AST_ACK: assert property (mbx_ack == $past(mbx_req))
    else $error("mailbox answer not one cycle after request");
  AST_MBX_PREOP: assert property (mbx_req && st_cur == 4'h2 |=> mbx_code == 8'h00)
    else $error("mailbox refused in preop");
  AST_PDO_IN: assert property (pdo_in_valid == $past(st_cur[2] | st_cur[3]))
    else $error("input data valid wrong for state");
  AST_OUT_FIRST: assert property (st_req && st_target == 4'h8 |-> pdo_out_valid)
    else $error("op requested before outputs valid");
  COV_OP: cover property (st_cur == 4'h8);
  COV_DOWN: cover property (st_req && st_target == 4'h1);
  COV_MBX: cover property (mbx_ack && mbx_code == 8'h00);
endmodule

// ### test_fieldbus_slave_state_machine.sv
// Purpose: Bench for both link ends plus a slave driven directly
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Second link lets the bench break the master's order on purpose
`timescale 1ns/1ps
module test_fieldbus_slave_state_machine;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic go = 1'b0;
  logic stop = 1'b0;
  logic [31:0] odata = 32'hCAFE0001;
  logic [1:0] phy = 2'h0;
  logic [3:0] mst_state;
  logic [31:0] mst_in;
  logic mst_fault;
  logic [3:0] disp;
  logic [3:0] disp2;
  logic [31:0] rx;
  logic [31:0] rx2;
  logic rxv;
  logic rxv2;
  int bad_count = 0;
  int n_compared = 0;
  fbsm_if lk();
  fbsm_if lk2();
  always #20 sys_clk_i = ~sys_clk_i;
  fbsm_master u_fbsm_master
  (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .link(lk.master),
    .go_i(go),
    .stop_i(stop),
    .out_data_i(odata),
    .slave_state_o(mst_state),
    .in_data_o(mst_in),
    .fault_o(mst_fault)
  );
  fbsm_slave u_fbsm_slave
  (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .link(lk.slave),
    .phy_link_i(phy),
    .disp_state_o(disp),
    .rx_pdo_o(rx),
    .rx_pdo_valid_o(rxv)
  );
  fbsm_slave u_fbsm_slave_b
  (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .link(lk2.slave),
    .phy_link_i(phy),
    .disp_state_o(disp2),
    .rx_pdo_o(rx2),
    .rx_pdo_valid_o(rxv2)
  );
  fbsm_asserts u_fbsm_asserts
  (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .st_req(lk.st_req),
    .st_target(lk.st_target),
    .st_cur(lk.st_cur),
    .st_err(lk.st_err),
    .mbx_req(lk.mbx_req),
    .mbx_ack(lk.mbx_ack),
    .mbx_code(lk.mbx_code),
    .pdo_out_valid(lk.pdo_out_valid),
    .pdo_in_valid(lk.pdo_in_valid)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // Request held one cycle, then one idle cycle so strobes never rise twice in a step
  task automatic st(input logic [3:0] tgt, input logic [3:0] cur, input logic err);
    lk2.st_req = 1'b1;
    lk2.st_target = tgt;
    tick(1);
    lk2.st_req = 1'b0;
    chk({lk2.st_err, lk2.st_cur}, {err, cur});
    tick(1);
  endtask
  task automatic mb(input logic [1:0] cmd, input logic [3:0] idx, input logic [31:0] wd,
                    input logic [7:0] code, input logic [31:0] rd);
    lk2.mbx_req = 1'b1;
    lk2.mbx_cmd = fbsm_pkg::fbsm_cmd_e'(cmd);
    lk2.mbx_index = idx;
    lk2.mbx_wdata = wd;
    tick(1);
    lk2.mbx_req = 1'b0;
    chk({lk2.mbx_ack, lk2.mbx_code}, {1'b1, code});
    if (cmd == 2'h0 && code == 8'h00)
      chk(lk2.mbx_rdata, rd);
    tick(1);
  endtask
  task automatic wst(input logic [3:0] s);
    for (int k = 0; k < 200 && mst_state !== s; k++)
      tick(1);
  endtask
  task automatic end_of_test;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    bad_count++;
    end_of_test();
  end
  initial
  begin
    lk2.st_req = 1'b0;
    lk2.st_target = 4'h1;
    lk2.mbx_req = 1'b0;
    lk2.mbx_cmd = fbsm_pkg::FBSM_SDO_READ;
    lk2.mbx_index = 4'h0;
    lk2.mbx_wdata = 32'h0;
    lk2.pdo_out_valid = 1'b0;
    lk2.pdo_out = 32'h0;
    tick(16);
    rst_n_i = 1'b1;
    chk({lk2.st_err, lk2.st_cur}, 5'h01);
    go = 1'b1;
    tick(1);
    go = 1'b0;
    wst(4'h8);
    chk(disp, 4'h8);
    chk(mst_state, 4'h8);
    tick(2);
    chk(rx, odata);
    chk(rxv, 1'b1);
    chk(mst_in, 32'h0);
    chk(mst_fault, 1'b0);
    stop = 1'b1;
    tick(1);
    stop = 1'b0;
    wst(4'h1);
    chk(disp, 4'h1);
    mb(2'h0, 4'h3, 32'h0, 8'h22, 32'h0);
    st(4'h4, 4'h1, 1'b1);
    st(4'h8, 4'h1, 1'b1);
    st(4'h3, 4'h1, 1'b1);
    st(4'h2, 4'h2, 1'b0);
    st(4'h8, 4'h2, 1'b1);
    for (int i = 0; i < 16; i++)
      mb(2'h1, i[3:0], 32'hA5000000 + i, 8'h00, 32'h0);
    for (int i = 0; i < 16; i++)
      mb(2'h0, i[3:0], 32'h0, 8'h00, 32'hA5000000 + i);
    // Select value given in index and data alike
    mb(2'h2, 4'h0, 32'h00000007, 8'h00, 32'h0);
    mb(2'h3, 4'h4, 32'h00000004, 8'h23, 32'h0);
    mb(2'h3, 4'h0, 32'h00000000, 8'h00, 32'h0);
    st(4'h4, 4'h4, 1'b0);
    chk(lk2.pdo_in_valid, 1'b1);
    chk(lk2.pdo_in, 32'hA5000007);
    mb(2'h2, 4'h0, 32'h00000003, 8'h21, 32'h0);
    mb(2'h0, 4'h1, 32'h0, 8'h00, 32'hA5000001);
    lk2.pdo_out_valid = 1'b1;
    lk2.pdo_out = 32'h12345678;
    tick(2);
    chk(rxv2, 1'b0);
    mb(2'h0, 4'h0, 32'h0, 8'h00, 32'hA5000000);
    st(4'h8, 4'h8, 1'b0);
    chk(rxv2, 1'b1);
    chk(rx2, 32'h12345678);
    mb(2'h0, 4'h0, 32'h0, 8'h00, 32'h12345678);
    st(4'h1, 4'h1, 1'b0);
    chk(disp2, 4'h1);
    phy = 2'h2;
    tick(3);
    chk({lk.port_link, lk2.port_link}, 4'hA);
    end_of_test();
  end
endmodule
